//--- logic/smx_map.svh
`ifndef SMX_MAP_SVH
`define SMX_MAP_SVH

// ----------------------------------------------------------------------------
// register byte offsets and decode
// ----------------------------------------------------------------------------
`define SMX_OFS_VIDEO_SEL   8'h00
`define SMX_OFS_MEM_SEL     8'h04
`define SMX_OFS_STRAP       8'h08
`define SMX_ADDR_W          8

// ----------------------------------------------------------------------------
// video pin select fields
// ----------------------------------------------------------------------------
`define SMX_VS_C2_LSB       10
`define SMX_VS_C1_LSB       12
`define SMX_VS_C0_LSB       14
`define SMX_VS_SYNC_BIT     16
`define SMX_VS_DEN_BIT      17
`define SMX_VS_FIELD_LSB    18
`define SMX_VS_XCLK_LSB     20
`define SMX_VS_OCLK_BIT     22
`define SMX_VS_RESET        32'h0000_0000

// ----------------------------------------------------------------------------
// memory pin select fields and strap layout
// ----------------------------------------------------------------------------
`define SMX_MS_UPPER_BIT    0
`define SMX_MS_BA0_LSB      2
`define SMX_MS_WIDTH_BIT    4
`define SMX_CFG_UPPER_BIT   0
`define SMX_CFG_BA0_LSB     1
`define SMX_CFG_WIDTH_BIT   3
`define SMX_ST_BOOT_LSB     0
`define SMX_ST_CFG_LSB      4
`define SMX_ST_VALID_BIT    8

// ----------------------------------------------------------------------------
// pin indices of the video pin group
// ----------------------------------------------------------------------------
`define SMX_PIN_C2          0
`define SMX_PIN_C1          1
`define SMX_PIN_C0          2
`define SMX_PIN_HSYNC       3
`define SMX_PIN_VSYNC       4
`define SMX_PIN_DEN         5
`define SMX_PIN_FIELD       6
`define SMX_PIN_XCLK        7
`define SMX_PIN_OCLK        8
`define SMX_NPINS           9

// ----------------------------------------------------------------------------
// strap capture timing and code maps
// ----------------------------------------------------------------------------
`define SMX_STRAP_FILL      2'd3
`define SMX_MAP_DEFAULT     8'hE4

`endif

//--- logic/smx_pkg.sv
package smx_pkg;

  // pin function chosen by a select field
  typedef enum logic [1:0] {
    SMX_FN_VIDEO = 2'b00,
    SMX_FN_GENIO = 2'b01,
    SMX_FN_ALT1  = 2'b10,
    SMX_FN_ALT2  = 2'b11
  } smx_func_t;

  // boot method from the boot strap
  typedef enum logic [1:0] {
    SMX_BOOT_NAND  = 2'b00,
    SMX_BOOT_FLASH = 2'b01,
    SMX_BOOT_MMCSD = 2'b10,
    SMX_BOOT_UART  = 2'b11
  } smx_boot_t;

  // captured strap pair
  typedef struct packed {
    logic [1:0] boot_method_strap;
    logic [3:0] async_mem_config_strap;
  } smx_strap_t;

  // memory interface pin settings
  typedef struct packed {
    logic       data_width_8bit;
    logic [1:0] bank_addr0_pin_select;
    logic       upper_addr_pin_select;
  } smx_mem_sel_t;

endpackage : smx_pkg

//--- logic/smx_strap_cap.sv
`timescale 1ns/1ns
`include "smx_map.svh"
module smx_strap_cap (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // strap pins
  input  wire smx_pkg::smx_strap_t strap_pin,
  // captured value
  output logic                   cap_valid_reg,
  output smx_pkg::smx_strap_t    cap_value_reg
);
  import smx_pkg::*;

  typedef enum logic [1:0] {
    SMX_CS_FILL   = 2'b00,
    SMX_CS_SETTLE = 2'b01,
    SMX_CS_DONE   = 2'b10
  } smx_cap_state_t;

  smx_strap_t     sync1_reg, sync2_reg, sync3_reg;
  smx_cap_state_t state_reg, state_next;
  logic [1:0]     fill_reg, fill_next;
  logic           cap_valid_next;
  smx_strap_t     cap_value_next;

  // ------------------------------------------------------------------------
  // three-stage synchroniser for the strap pins
  // ------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= strap_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // capture once the chain is filled and the last two stages agree
  always_comb begin
    state_next     = state_reg;
    fill_next      = fill_reg;
    cap_valid_next = cap_valid_reg;
    cap_value_next = cap_value_reg;
    case (state_reg)
      SMX_CS_FILL: begin
        fill_next = fill_reg + 2'd1;
        if (fill_reg == `SMX_STRAP_FILL) begin
          state_next = SMX_CS_SETTLE;
        end
      end
      SMX_CS_SETTLE: begin
        if (sync2_reg == sync3_reg) begin
          cap_value_next = sync3_reg;
          cap_valid_next = 1'b1;
          state_next     = SMX_CS_DONE;
        end
      end
      SMX_CS_DONE: begin
        state_next = SMX_CS_DONE;       // held until the next power-on reset
      end
      default: begin
        state_next = SMX_CS_FILL;
      end
    endcase
  end

  // capture registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= SMX_CS_FILL;
      fill_reg      <= 2'd0;
      cap_valid_reg <= 1'b0;
      cap_value_reg <= '0;
    end else begin
      state_reg     <= state_next;
      fill_reg      <= fill_next;
      cap_valid_reg <= cap_valid_next;
      cap_value_reg <= cap_value_next;
    end
  end

endmodule : smx_strap_cap

//--- logic/smx_top.sv
`timescale 1ns/1ns
`include "smx_map.svh"
module smx_top #(
  parameter logic [7:0] C2_MAP     = `SMX_MAP_DEFAULT,
  parameter logic [7:0] C1_MAP     = `SMX_MAP_DEFAULT,
  parameter logic [7:0] C0_MAP     = `SMX_MAP_DEFAULT,
  parameter logic [7:0] FIELD_MAP  = `SMX_MAP_DEFAULT,
  parameter logic [7:0] XCLK_MAP   = `SMX_MAP_DEFAULT
) (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`SMX_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // strap pins
  input  wire smx_pkg::smx_strap_t     strap_pin,
  // captured boot method and memory pin settings
  output smx_pkg::smx_boot_t           boot_method_reg,
  output logic                         strap_valid_reg,
  output smx_pkg::smx_mem_sel_t        mem_sel_reg,
  // video pin pads
  input  wire logic [`SMX_NPINS-1:0]   pin_in,
  output logic      [`SMX_NPINS-1:0]   pin_out_reg,
  output logic      [`SMX_NPINS-1:0]   pin_oe_n_reg,
  // function sources
  input  wire logic [`SMX_NPINS-1:0]   video_encoder_out,
  input  wire logic [`SMX_NPINS-1:0]   general_io_out,
  input  wire logic [`SMX_NPINS-1:0]   general_io_oe_n,
  input  wire logic                    pwm_group2_d,
  input  wire logic                    realtime_output_3,
  input  wire logic                    pwm_group3_a,
  input  wire logic                    pwm_group3_b,
  input  wire logic                    pwm_group3_c,
  input  wire logic                    pwm_group3_d,
  input  wire logic                    video_red2,
  input  wire logic                    video_blue2,
  // inputs seen through the pads
  output logic      [`SMX_NPINS-1:0]   general_io_in_reg,
  output logic                         external_video_clock_reg
);
  import smx_pkg::*;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------

  // code to function through a map; indices past the alternates are general io
  function automatic smx_func_t smx_decode(input logic [1:0] code,
                                           input logic [7:0] map,
                                           input logic [1:0] n_alt);
    logic [1:0] idx;
    idx = map[{code, 1'b0} +: 2];
    case (idx)
      2'd0:    smx_decode = SMX_FN_VIDEO;
      2'd1:    smx_decode = SMX_FN_GENIO;
      2'd2:    smx_decode = (n_alt >= 2'd1) ? SMX_FN_ALT1 : SMX_FN_GENIO;
      default: smx_decode = (n_alt >= 2'd2) ? SMX_FN_ALT2 : SMX_FN_GENIO;
    endcase
  endfunction : smx_decode

  // single select bit: 0 encoder, 1 general I/O
  function automatic smx_func_t smx_bit(input logic sel);
    smx_bit = sel ? SMX_FN_GENIO : SMX_FN_VIDEO;
  endfunction : smx_bit

  // --------------------------------------------------------------------------
  // strap capture
  // --------------------------------------------------------------------------
  logic       cap_valid;
  smx_strap_t cap_value;

  smx_strap_cap u_strap (
    .pclk          (pclk),
    .presetn       (presetn),
    .strap_pin     (strap_pin),
    .cap_valid_reg (cap_valid),
    .cap_value_reg (cap_value)
  );

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  logic [31:0]  video_pin_select_reg, video_pin_select_next;
  smx_mem_sel_t mem_sel_next;
  smx_boot_t    boot_method_next;
  logic         strap_valid_next;
  logic [31:0]  prdata_next;
  logic         pready_next, pslverr_next;
  logic         wr_en, setup, hit;
  logic [31:0]  rd_word;
  logic [31:0]  vs_mask;
  logic         strap_load;

  assign setup      = psel & ~penable;
  assign wr_en      = psel & penable & pready & pwrite;
  assign strap_load = cap_valid & ~strap_valid_reg;

  // writable bits of the video select register
  assign vs_mask = (32'h0000_0003 << `SMX_VS_C2_LSB)
                 | (32'h0000_0003 << `SMX_VS_C1_LSB)
                 | (32'h0000_0003 << `SMX_VS_C0_LSB)
                 | (32'h0000_0001 << `SMX_VS_SYNC_BIT)
                 | (32'h0000_0001 << `SMX_VS_DEN_BIT)
                 | (32'h0000_0003 << `SMX_VS_FIELD_LSB)
                 | (32'h0000_0003 << `SMX_VS_XCLK_LSB)
                 | (32'h0000_0001 << `SMX_VS_OCLK_BIT);

  // read mux for the setup cycle
  always_comb begin
    rd_word = 32'h0000_0000;
    hit     = 1'b1;
    case (paddr)
      `SMX_OFS_VIDEO_SEL: begin
        rd_word = video_pin_select_reg;
      end
      `SMX_OFS_MEM_SEL: begin
        rd_word[`SMX_MS_UPPER_BIT]         = mem_sel_reg.upper_addr_pin_select;
        rd_word[`SMX_MS_BA0_LSB +: 2]      = mem_sel_reg.bank_addr0_pin_select;
        rd_word[`SMX_MS_WIDTH_BIT]         = mem_sel_reg.data_width_8bit;
      end
      `SMX_OFS_STRAP: begin
        rd_word[`SMX_ST_BOOT_LSB +: 2]     = boot_method_reg;
        rd_word[`SMX_ST_CFG_LSB +: 4]      = cap_value.async_mem_config_strap;
        rd_word[`SMX_ST_VALID_BIT]         = strap_valid_reg;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // next register values: strap load first, then software writes
  always_comb begin
    video_pin_select_next = video_pin_select_reg;
    mem_sel_next          = mem_sel_reg;
    boot_method_next      = boot_method_reg;
    strap_valid_next      = strap_valid_reg | cap_valid;
    pready_next           = setup;                 // one wait-free answer
    pslverr_next          = setup & ~hit;
    prdata_next           = (setup & ~pwrite) ? rd_word : 32'h0000_0000;
    if (strap_load) begin
      boot_method_next = smx_boot_t'(cap_value.boot_method_strap);
      mem_sel_next.upper_addr_pin_select =
        cap_value.async_mem_config_strap[`SMX_CFG_UPPER_BIT];
      mem_sel_next.bank_addr0_pin_select =
        cap_value.async_mem_config_strap[`SMX_CFG_BA0_LSB +: 2];
      mem_sel_next.data_width_8bit =
        cap_value.async_mem_config_strap[`SMX_CFG_WIDTH_BIT];
    end
    if (wr_en && paddr == `SMX_OFS_VIDEO_SEL) begin
      video_pin_select_next = pwdata & vs_mask;
    end
    if (wr_en && paddr == `SMX_OFS_MEM_SEL) begin
      mem_sel_next.upper_addr_pin_select = pwdata[`SMX_MS_UPPER_BIT];
      mem_sel_next.bank_addr0_pin_select = pwdata[`SMX_MS_BA0_LSB +: 2];
      mem_sel_next.data_width_8bit       = pwdata[`SMX_MS_WIDTH_BIT];
    end
  end

  // register bank and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      video_pin_select_reg <= `SMX_VS_RESET;
      mem_sel_reg          <= '0;
      boot_method_reg      <= SMX_BOOT_NAND;
      strap_valid_reg      <= 1'b0;
      prdata               <= 32'h0000_0000;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
    end else begin
      video_pin_select_reg <= video_pin_select_next;
      mem_sel_reg          <= mem_sel_next;
      boot_method_reg      <= boot_method_next;
      strap_valid_reg      <= strap_valid_next;
      prdata               <= prdata_next;
      pready               <= pready_next;
      pslverr              <= pslverr_next;
    end
  end

  // --------------------------------------------------------------------------
  // pin function decode
  // --------------------------------------------------------------------------
  smx_func_t func [`SMX_NPINS];

  always_comb begin
    func[`SMX_PIN_C2]     = smx_decode(video_pin_select_reg[`SMX_VS_C2_LSB +: 2], C2_MAP, 2'd2);
    func[`SMX_PIN_C1]     = smx_decode(video_pin_select_reg[`SMX_VS_C1_LSB +: 2], C1_MAP, 2'd1);
    func[`SMX_PIN_C0]     = smx_decode(video_pin_select_reg[`SMX_VS_C0_LSB +: 2], C0_MAP, 2'd1);
    func[`SMX_PIN_HSYNC]  = smx_bit(video_pin_select_reg[`SMX_VS_SYNC_BIT]);
    func[`SMX_PIN_VSYNC]  = smx_bit(video_pin_select_reg[`SMX_VS_SYNC_BIT]);
    func[`SMX_PIN_DEN]    = smx_bit(video_pin_select_reg[`SMX_VS_DEN_BIT]);
    func[`SMX_PIN_FIELD]  = smx_decode(video_pin_select_reg[`SMX_VS_FIELD_LSB +: 2], FIELD_MAP, 2'd2);
    func[`SMX_PIN_XCLK]   = smx_decode(video_pin_select_reg[`SMX_VS_XCLK_LSB +: 2], XCLK_MAP, 2'd2);
    func[`SMX_PIN_OCLK]   = smx_bit(video_pin_select_reg[`SMX_VS_OCLK_BIT]);
  end

  // --------------------------------------------------------------------------
  // pad drive
  // --------------------------------------------------------------------------
  logic [`SMX_NPINS-1:0] alt1_src, alt2_src;
  logic [`SMX_NPINS-1:0] pin_out_next, pin_oe_n_next;

  // alternate sources per pin, zero where a pin has none
  always_comb begin
    alt1_src = '0;
    alt2_src = '0;
    alt1_src[`SMX_PIN_C2]     = pwm_group2_d;
    alt2_src[`SMX_PIN_C2]     = realtime_output_3;
    alt1_src[`SMX_PIN_C1]     = pwm_group3_a;
    alt1_src[`SMX_PIN_C0]     = pwm_group3_b;
    alt1_src[`SMX_PIN_FIELD]  = video_red2;
    alt2_src[`SMX_PIN_FIELD]  = pwm_group3_c;
    alt1_src[`SMX_PIN_XCLK]   = video_blue2;
    alt2_src[`SMX_PIN_XCLK]   = pwm_group3_d;
  end

  // chosen source onto each pad; the external clock pin is an input in video mode
  always_comb begin
    for (int i = 0; i < `SMX_NPINS; i++) begin
      case (func[i])
        SMX_FN_VIDEO: begin
          pin_out_next[i]  = video_encoder_out[i];
          pin_oe_n_next[i] = (i == `SMX_PIN_XCLK);
        end
        SMX_FN_GENIO: begin
          pin_out_next[i]  = general_io_out[i];
          pin_oe_n_next[i] = general_io_oe_n[i];
        end
        SMX_FN_ALT1: begin
          pin_out_next[i]  = alt1_src[i];
          pin_oe_n_next[i] = 1'b0;
        end
        default: begin
          pin_out_next[i]  = alt2_src[i];
          pin_oe_n_next[i] = 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // pad input synchroniser: a change counts when stages two and three agree
  // --------------------------------------------------------------------------
  logic [`SMX_NPINS-1:0] in_s1_reg, in_s2_reg, in_s3_reg, in_stable_reg, in_stable_next;
  logic [`SMX_NPINS-1:0] genio_mask, general_io_in_next;
  logic                  ext_clk_next;

  always_comb begin
    for (int i = 0; i < `SMX_NPINS; i++) begin
      in_stable_next[i] = (in_s2_reg[i] == in_s3_reg[i]) ? in_s3_reg[i] : in_stable_reg[i];
      genio_mask[i]     = (func[i] == SMX_FN_GENIO);
    end
    general_io_in_next = in_stable_reg & genio_mask;
    ext_clk_next       = (func[`SMX_PIN_XCLK] == SMX_FN_VIDEO) & in_stable_reg[`SMX_PIN_XCLK];
  end

  // pad registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_reg                <= '0;
      in_s2_reg                <= '0;
      in_s3_reg                <= '0;
      in_stable_reg            <= '0;
      general_io_in_reg        <= '0;
      external_video_clock_reg <= 1'b0;
      pin_out_reg              <= '0;
      pin_oe_n_reg             <= '1;  // pads released during reset
    end else begin
      in_s1_reg                <= pin_in;
      in_s2_reg                <= in_s1_reg;
      in_s3_reg                <= in_s2_reg;
      in_stable_reg            <= in_stable_next;
      general_io_in_reg        <= general_io_in_next;
      external_video_clock_reg <= ext_clk_next;
      pin_out_reg              <= pin_out_next;
      pin_oe_n_reg             <= pin_oe_n_next;
    end
  end

endmodule : smx_top

//--- testbench/smx_board_model.sv
`timescale 1ns/1ns
module smx_board_model (
  // board settings
  input  wire logic [5:0]          strap_set,
  input  wire logic [8:0]          board,
  // device pads
  input  wire logic [8:0]          pout,
  input  wire logic [8:0]          poe,
  output smx_pkg::smx_strap_t      strap_pin,
  output logic [8:0]               pin_in
);
  // straps held steady; each pad shows whichever side drives it
  assign strap_pin = strap_set;
  assign pin_in = (~poe & pout) | (poe & board);
endmodule : smx_board_model

//--- testbench/smx_top_asserts.sv
`timescale 1ns/1ns
module smx_top_asserts (
  // bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // straps
  input wire smx_pkg::smx_strap_t strap_pin,
  input wire smx_pkg::smx_boot_t boot_method_reg,
  input wire logic strap_valid_reg,
  input wire smx_pkg::smx_mem_sel_t mem_sel_reg,
  // pads and sources
  input wire logic [8:0] pin_out_reg,
  input wire logic [8:0] pin_oe_n_reg,
  input wire logic [8:0] video_encoder_out,
  input wire logic [8:0] general_io_oe_n,
  input wire logic realtime_output_3,
  input wire logic video_red2
);
  import smx_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // video select write taken
  sequence vs_wr;
    psel && penable && pready && pwrite && paddr == 8'h00;
  endsequence
  // strap capture moment
  sequence cap;
    $rose(strap_valid_reg);
  endsequence
  boot_capture_a: assert property (cap |-> boot_method_reg == strap_pin.boot_method_strap)
    else $error("boot method not taken from strap");
  strap_hold_a: assert property (strap_valid_reg |=> strap_valid_reg && $stable(boot_method_reg))
    else $error("captured strap not held");
  mem_default_a: assert property (cap |-> mem_sel_reg[3:1] == strap_pin.async_mem_config_strap[3:1])
    else $error("memory defaults not from strap");
  upper_default_a: assert property (cap |-> mem_sel_reg[0] == strap_pin.async_mem_config_strap[0])
    else $error("upper address default not from strap");
  sync_pair_a: assert property (vs_wr ##0 pwdata[16] |-> ##[2:3] pin_oe_n_reg[4:3] == general_io_oe_n[4:3])
    else $error("sync pins not moved together");
  den_video_a: assert property (vs_wr ##0 !pwdata[17] |-> ##[2:3] pin_out_reg[5] == video_encoder_out[5])
    else $error("display enable not from encoder");
  c2_rto_a: assert property (vs_wr ##0 pwdata[11:10] == 2'h3 |-> ##[2:3] pin_out_reg[0] == realtime_output_3)
    else $error("chroma2 not on realtime output");
  c1_spare_a: assert property (vs_wr ##0 pwdata[13:12] == 2'h3 |-> ##[2:3] pin_oe_n_reg[1] == general_io_oe_n[1])
    else $error("chroma1 spare code not general io");
  field_red_a: assert property (vs_wr ##0 pwdata[19:18] == 2'h2 |-> ##[2:3] pin_out_reg[6] == video_red2)
    else $error("field pin not red bit");
  ext_video_a: assert property (vs_wr ##0 pwdata[21:20] == 2'h0 |-> ##[2:3] pin_oe_n_reg[7])
    else $error("clock input pin driven");
endmodule : smx_top_asserts
bind smx_top smx_top_asserts u_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .paddr, .pwdata,
  .strap_pin, .boot_method_reg, .strap_valid_reg, .mem_sel_reg, .pin_out_reg, .pin_oe_n_reg,
  .video_encoder_out, .general_io_oe_n, .realtime_output_3, .video_red2);

//--- testbench/test_strap_capture_and_video_pin_mux.sv
`timescale 1ns/1ns
module test_strap_capture_and_video_pin_mux;
  import smx_pkg::*;
  // expected result note
  typedef struct {
    logic [34:0] exp;
    logic [34:0] care;
    string       what;
  } smx_note_t;
  logic             pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, look = '0;
  logic [7:0]       paddr = '0, src = '0;
  logic [31:0]      pwdata = '0, prdata, v;
  logic             pready, pslverr, strap_valid_reg, ext_clk;
  logic [8:0]       enc = '0, gout = '0, goe = '0, board = '0, pin_in, gin, pout, poe;
  logic [5:0]       strap_set = '0;
  logic [3:0]       ms;
  logic [63:0]      r;
  smx_strap_t       strap_pin;
  smx_boot_t        boot_method_reg;
  smx_mem_sel_t     mem_sel_reg;
  smx_note_t        note_q[$];
  integer           seed = 97944, fail_count = 0, samples_checked = 0;

  always #5 pclk = ~pclk;

  smx_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .strap_pin, .boot_method_reg, .strap_valid_reg, .mem_sel_reg, .pin_in, .pin_out_reg(pout),
    .pin_oe_n_reg(poe), .video_encoder_out(enc), .general_io_out(gout), .general_io_oe_n(goe),
    .pwm_group2_d(src[0]), .realtime_output_3(src[1]), .pwm_group3_a(src[2]), .pwm_group3_b(src[3]),
    .pwm_group3_c(src[4]), .pwm_group3_d(src[5]), .video_red2(src[6]), .video_blue2(src[7]),
    .general_io_in_reg(gin), .external_video_clock_reg(ext_clk));
  smx_board_model u_board (.strap_set, .board, .pout, .poe, .strap_pin, .pin_in);

  // expected pad state for select word w and memory settings m
  function automatic void expect_state(input logic [31:0] w, input logic [3:0] m,
                                       output logic [34:0] e, output logic [34:0] c);
    logic [1:0] code [9];
    logic [8:0] o, n, g, a1, a2;
    code = '{w[11:10], (w[13:12] == 2'h3) ? 2'h1 : w[13:12], (w[15:14] == 2'h3) ? 2'h1 : w[15:14],
             {1'h0, w[16]}, {1'h0, w[16]}, {1'h0, w[17]}, w[19:18], w[21:20], {1'h0, w[22]}};
    a1 = {1'h0, src[7:6], 3'h0, src[3:2], src[0]};
    a2 = {1'h0, src[5:4], 5'h0, src[1]};
    for (int i = 0; i < 9; i++) begin
      case (code[i])
        2'h0: begin o[i] = enc[i]; n[i] = (i == 7); end
        2'h1: begin o[i] = gout[i]; n[i] = goe[i]; end
        2'h2: begin o[i] = a1[i]; n[i] = 1'h0; end
        default: begin o[i] = a2[i]; n[i] = 1'h0; end
      endcase
      g[i] = (code[i] == 2'h1) ? (n[i] ? board[i] : o[i]) : 1'h0;
    end
    e = {1'h1, strap_set[5:4], m, g, (code[7] == 2'h0) & board[7], o, n};
    c = '1;
  endfunction : expect_state

  // apb transfer; a read leaves a note of its answer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int i;
    if (!wr) note_q.push_back('{{2'h0, e}, '1, "prdata"});
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    if (pready !== 1'h1) begin
      fail_count++;
      end_of_test();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  // note the pad state and let the monitor look
  task automatic check_state(input logic [31:0] w, input string what);
    logic [34:0] e, c;
    expect_state(w, ms, e, c);
    note_q.push_back('{e, c, what});
    look <= 1'h1;
    @(posedge pclk);
    look <= 1'h0;
  endtask : check_state

  // compare each result with the oldest note
  always @(posedge pclk) begin
    smx_note_t nt;
    logic [34:0] obs;
    if (look || (psel && penable && pready === 1'h1 && !pwrite)) begin
      obs = look ? {strap_valid_reg, boot_method_reg, mem_sel_reg, gin, ext_clk, pout, poe} : {2'h0, pslverr, prdata};
      if (note_q.size() > 0) begin
        nt = note_q.pop_front();
      end else begin
        nt = '{'0, '1, "queue"};
      end
      samples_checked++;
      if (((obs ^ nt.exp) & nt.care) !== 35'h0) begin
        $display("ERROR %s expected %h seen %h", nt.what, nt.exp, obs);
        fail_count++;
      end
    end
  end

  task automatic end_of_test;
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // bound on the whole run
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end

  // one power-on per boot code, then random pad routing
  initial begin
    for (int k = 0; k < 4; k++) begin
      strap_set <= {k[1:0], k[0], k[1:0], ~k[0]};
      presetn <= 1'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      repeat (12) @(posedge pclk);
      ms = strap_set[3:0];
      check_state(32'h0000_0000, "reset pads");
      apb(1'h1, 8'h08, 32'hFFFF_FFFF, '0);
      apb(1'h0, 8'h08, '0, {9'h1, ms, 2'h0, strap_set[5:4]});
      apb(1'h0, 8'h04, '0, {28'h0, ms[3:1], 1'h0, ms[0]});
      apb(1'h0, 8'h20, '0, {1'h1, 32'h0});
      repeat (6) begin
        r = {$random(seed), $random(seed)};
        v = $random(seed);
        {enc, gout, goe, board, src} <= r[43:0];
        apb(1'h1, 8'h00, v, '0);
        repeat (8) @(posedge pclk);
        check_state(v, "pads");
        apb(1'h0, 8'h00, '0, {1'h0, v & 32'h007F_FC00});
      end
      r[31:0] = $random(seed);
      apb(1'h1, 8'h04, r[31:0], '0);
      ms = {r[4], r[3:2], r[0]};
      repeat (2) @(posedge pclk);
      check_state(v, "memory select");
    end
    end_of_test();
  end
endmodule : test_strap_capture_and_video_pin_mux
